// ===== design/gpxp_pkg.sv
// Contract
// [RQ1] mode register 0x00 configures pins 3..0
// [RQ2] mode 00 open-drain, 10 push-pull, x1 input
// [RQ3] mode register 0x07 configures pins 7..4
// [RQ4] level register write drives output pins
// [RQ5] level register read returns live pins
// [RQ6] control bit 7 flags selected edge
// [RQ7] control bit 6 enables edge interrupts
// [RQ8] control bit 5 picks rising or falling
// [RQ9] control bits 4..0 ignored, read zero
// [RQ10] all four registers reset to zero
// [RQ11] master sends revision command, filler, then reads
// [RQ12] revision returned as two BCD bytes, MSB first
// [RQ13] reading control register clears the flag
// [RQ14] enabled edge drives active-low interrupt pin
// [RQ15] edge pin synchronised; no flag while disabled
package gpxp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned MODE_W = 2;

  localparam logic [ADDR_W-1:0] ADDR_MODE_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_MODE_HIGH = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_CTL = 8'h08;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [NUM_PINS-1:0] OE_RESET = 8'hFF;

  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned ENABLE_BIT = 6;
  localparam int unsigned POLARITY_BIT = 5;

  localparam logic [MODE_W-1:0] MODE_OPEN_DRAIN = 2'h0;
  localparam logic [MODE_W-1:0] MODE_PUSH_PULL = 2'h2;
  localparam logic [MODE_W-1:0] MODE_INPUT = 2'h1;
  localparam logic POL_FALLING = 1'h1;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gpxp_req_type;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } gpxp_rsp_type;

  // low mode bit set means the pin only listens
  function automatic logic gpxp_is_input(input logic [MODE_W-1:0] mode);
    return mode[0];
  endfunction

  function automatic logic gpxp_is_push_pull(input logic [MODE_W-1:0] mode);
    return mode == MODE_PUSH_PULL;
  endfunction
endpackage

// ===== design/gpxp_port.sv
`timescale 1ns/100ps
module gpxp_port #(
  parameter logic [7:0] REV_MSB = 8'h12, // arbitrary revision value
  parameter logic [7:0] REV_LSB = 8'h34 // arbitrary revision value
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic sys_rst, // async reset, active high
  input wire gpxp_pkg::gpxp_req_type reg_req, // register access from command decoder
  output gpxp_pkg::gpxp_rsp_type reg_rsp, // read answer, one cycle later
  input wire logic rev_start, // revision command and filler received
  input wire logic rev_rd, // fetch next revision byte
  input wire logic [7:0] pin_in, // port pin levels from pads
  output logic [7:0] pin_out, // port pin output values
  output logic [7:0] pin_oe, // port pin output enables
  input wire logic edge_irq_pin, // dedicated edge interrupt pin
  output logic int_n // interrupt pin, active low
);
  logic [7:0] mode_low_q;
  logic [7:0] mode_high_q;
  logic [7:0] level_q;
  logic en_q;
  logic pol_q;
  logic flag_q;
  logic flag_d;
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  logic edge_s1_q;
  logic edge_s2_q;
  logic edge_s3_q;
  logic rev_ptr_q;
  wire [7:0] out_d;
  wire [7:0] oe_d;
  logic [15:0] mode_all;

  wire hit_mode_low = reg_req.addr == gpxp_pkg::ADDR_MODE_LOW;
  wire hit_level = reg_req.addr == gpxp_pkg::ADDR_LEVEL;
  wire hit_mode_high = reg_req.addr == gpxp_pkg::ADDR_MODE_HIGH;
  wire hit_ctl = reg_req.addr == gpxp_pkg::ADDR_EDGE_CTL;
  wire wr_mode_low = reg_req.wr && hit_mode_low;
  wire wr_level = reg_req.wr && hit_level;
  wire wr_mode_high = reg_req.wr && hit_mode_high;
  wire wr_ctl = reg_req.wr && hit_ctl;
  wire rd_ctl = reg_req.rd && hit_ctl;

  // edge detect looks only at the second and third stages
  wire rise = edge_s2_q && !edge_s3_q;
  wire fall = !edge_s2_q && edge_s3_q;
  wire edge_hit = en_q && ((pol_q == gpxp_pkg::POL_FALLING) ? fall : rise); // [RQ8]
  wire en_d = wr_ctl ? reg_req.wdata[gpxp_pkg::ENABLE_BIT] : en_q;

  // a new edge in the same cycle as the clearing read keeps the flag set
  assign flag_d = edge_hit ? 1'b1 : (rd_ctl ? 1'b0 : flag_q); // [RQ6] [RQ13] [RQ15]

  wire [7:0] ctl_view = {flag_q, en_q, pol_q, 5'h00}; // [RQ9]
  wire [7:0] reg_mux =
    hit_mode_low ? mode_low_q :
    hit_level ? pin_s2_q : // [RQ5]
    hit_mode_high ? mode_high_q :
    hit_ctl ? ctl_view :
    gpxp_pkg::ZERO_BYTE;
  wire [7:0] rev_byte = rev_ptr_q ? REV_LSB : REV_MSB; // [RQ12]

  assign mode_all = {mode_high_q, mode_low_q}; // [RQ1] [RQ3]

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      wire [1:0] mode = mode_all[2*gi +: 2];
      wire is_in = gpxp_pkg::gpxp_is_input(mode);
      wire is_pp = gpxp_pkg::gpxp_is_push_pull(mode);
      // open drain only pulls low; a 1 leaves the pad to the pull-up
      assign oe_d[gi] = !is_in && (is_pp || !level_q[gi]); // [RQ2]
      assign out_d[gi] = is_pp && level_q[gi]; // [RQ4]
    end
  endgenerate

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_s1_q <= gpxp_pkg::REG_RESET;
      pin_s2_q <= gpxp_pkg::REG_RESET;
      edge_s1_q <= 1'b0;
      edge_s2_q <= 1'b0;
      edge_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      edge_s1_q <= edge_irq_pin; // [RQ15]
      edge_s2_q <= edge_s1_q;
      edge_s3_q <= edge_s2_q;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_low_q <= gpxp_pkg::REG_RESET; // [RQ10]
      mode_high_q <= gpxp_pkg::REG_RESET;
      level_q <= gpxp_pkg::REG_RESET;
      en_q <= 1'b0;
      pol_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      if (wr_mode_low)
        mode_low_q <= reg_req.wdata; // [RQ1]
      if (wr_mode_high)
        mode_high_q <= reg_req.wdata; // [RQ3]
      if (wr_level)
        level_q <= reg_req.wdata; // [RQ4]
      en_q <= en_d; // [RQ7]
      if (wr_ctl)
        pol_q <= reg_req.wdata[gpxp_pkg::POLARITY_BIT]; // [RQ8]
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_out <= gpxp_pkg::REG_RESET;
      pin_oe <= gpxp_pkg::OE_RESET;
      int_n <= 1'b1;
    end
    else
    begin
      pin_out <= out_d;
      pin_oe <= oe_d;
      int_n <= !(flag_d && en_d); // [RQ14]
    end
  end

  // revision reads take priority over a register read in the same cycle
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rsp <= '0;
      rev_ptr_q <= 1'b0;
    end
    else
    begin
      reg_rsp.valid <= reg_req.rd || rev_rd;
      reg_rsp.data <= rev_rd ? rev_byte : reg_mux;
      if (rev_start)
        rev_ptr_q <= 1'b0; // [RQ12]
      else if (rev_rd)
        rev_ptr_q <= !rev_ptr_q;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  property p_open_drain;
    (mode_all[1:0] == gpxp_pkg::MODE_OPEN_DRAIN) |=> pin_oe[0] == !$past(level_q[0]) && !pin_out[0];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin 0 wrong"); // [RQ2]

  property p_input_only;
    mode_all[6] |=> !pin_oe[3];
  endproperty
  a_input_only: assert property (p_input_only) else $error("input pin 3 driven"); // [RQ2]

  sequence s_pp_write;
    wr_level && mode_all[3:2] == gpxp_pkg::MODE_PUSH_PULL ##1 mode_all[3:2] == gpxp_pkg::MODE_PUSH_PULL;
  endsequence
  property p_push_pull;
    s_pp_write |=> pin_oe[1] && pin_out[1] == $past(reg_req.wdata[1], 2);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull pin 1 wrong"); // [RQ4]

  sequence s_high_input;
    wr_mode_high && reg_req.wdata[0] ##1 !wr_mode_high;
  endsequence
  property p_mode_high;
    s_high_input |=> !pin_oe[4];
  endproperty
  a_mode_high: assert property (p_mode_high) else $error("pin 4 mode not applied"); // [RQ3]

  property p_level_read;
    reg_req.rd && hit_level && !rev_rd |=> reg_rsp.valid && reg_rsp.data == $past(pin_s2_q);
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read not live"); // [RQ5]

  property p_flag_set;
    edge_hit |=> flag_q ##1 (flag_q || $past(rd_ctl));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge flag not set"); // [RQ6]

  property p_disabled;
    !en_q && !flag_q |=> !flag_q;
  endproperty
  a_disabled: assert property (p_disabled) else $error("flag set while disabled"); // [RQ15]

  property p_polarity;
    en_q && pol_q && rise && !flag_q |=> !flag_q;
  endproperty
  a_polarity: assert property (p_polarity) else $error("wrong edge accepted"); // [RQ8]

  property p_reserved;
    rd_ctl && !rev_rd |=> reg_rsp.data[4:0] == 5'h00 && reg_rsp.data[7] == $past(flag_q);
  endproperty
  a_reserved: assert property (p_reserved) else $error("control read wrong"); // [RQ9]

  property p_read_clear;
    rd_ctl && !edge_hit |=> !flag_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read"); // [RQ13]

  property p_irq_pin;
    edge_hit && en_d |=> !int_n;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not asserted"); // [RQ14]

  property p_enable_gate;
    !en_q |=> int_n || $past(wr_ctl);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("interrupt while disabled"); // [RQ7]

  sequence s_rev_pair;
    rev_start ##1 (rev_rd && !rev_start) ##1 (rev_rd && !rev_start);
  endsequence
  property p_revision;
    s_rev_pair |=> reg_rsp.data == REV_LSB && $past(reg_rsp.data) == REV_MSB;
  endproperty
  a_revision: assert property (p_revision) else $error("revision order wrong"); // [RQ12]

  sequence s_rev_first;
    rev_start ##1 (rev_rd && !rev_start);
  endsequence
  property p_rev_first;
    s_rev_first |=> reg_rsp.valid && reg_rsp.data == REV_MSB;
  endproperty
  a_rev_first: assert property (p_rev_first) else $error("revision did not rewind"); // [RQ12]

  property p_mode_low_wr;
    wr_mode_low |=> mode_low_q == $past(reg_req.wdata);
  endproperty
  a_mode_low_wr: assert property (p_mode_low_wr) else $error("low mode write lost"); // [RQ1]

  property p_mode_high_wr;
    wr_mode_high |=> mode_high_q == $past(reg_req.wdata);
  endproperty
  a_mode_high_wr: assert property (p_mode_high_wr) else $error("high mode write lost"); // [RQ3]

  property p_level_wr;
    wr_level |=> level_q == $past(reg_req.wdata);
  endproperty
  a_level_wr: assert property (p_level_wr) else $error("level write lost"); // [RQ4]

  property p_mode_low_rd;
    reg_req.rd && hit_mode_low && !rev_rd |=> reg_rsp.data == $past(mode_low_q);
  endproperty
  a_mode_low_rd: assert property (p_mode_low_rd) else $error("low mode read wrong"); // [RQ1]

  property p_mode_high_rd;
    reg_req.rd && hit_mode_high && !rev_rd |=> reg_rsp.data == $past(mode_high_q);
  endproperty
  a_mode_high_rd: assert property (p_mode_high_rd) else $error("high mode read wrong"); // [RQ3]

  property p_input_pin7;
    mode_all[14] |=> !pin_oe[7];
  endproperty
  a_input_pin7: assert property (p_input_pin7) else $error("input pin 7 driven"); // [RQ2]

  property p_pp_pin6;
    mode_all[13:12] == gpxp_pkg::MODE_PUSH_PULL |=> pin_oe[6] && pin_out[6] == $past(level_q[6]);
  endproperty
  a_pp_pin6: assert property (p_pp_pin6) else $error("push-pull pin 6 wrong"); // [RQ2]

  property p_od_pin7;
    mode_all[15:14] == gpxp_pkg::MODE_OPEN_DRAIN |=> !pin_out[7] && pin_oe[7] == !$past(level_q[7]);
  endproperty
  a_od_pin7: assert property (p_od_pin7) else $error("open-drain pin 7 wrong"); // [RQ2]

  // software may not set the flag; only a pin edge does
  property p_flag_no_write;
    wr_ctl && !edge_hit && !flag_q |=> !flag_q;
  endproperty
  a_flag_no_write: assert property (p_flag_no_write) else $error("flag set by write"); // [RQ6]

  property p_pol_write;
    wr_ctl |=> pol_q == $past(reg_req.wdata[gpxp_pkg::POLARITY_BIT]);
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("polarity write lost"); // [RQ8]

  property p_en_write;
    wr_ctl |=> en_q == $past(reg_req.wdata[gpxp_pkg::ENABLE_BIT]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost"); // [RQ7]

  property p_irq_hold;
    !int_n && !rd_ctl && !wr_ctl |=> !int_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt released early"); // [RQ14]

  sequence s_pin_rise;
    en_q && !pol_q && !wr_ctl && edge_s1_q && !edge_s2_q && !edge_s3_q;
  endsequence
  property p_sync_rise;
    s_pin_rise |=> ##1 flag_q;
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("synchronised rise missed"); // [RQ15]

  sequence s_pin_fall;
    en_q && pol_q && !wr_ctl && !edge_s1_q && edge_s2_q && edge_s3_q;
  endsequence
  property p_sync_fall;
    s_pin_fall |=> ##1 flag_q;
  endproperty
  a_sync_fall: assert property (p_sync_fall) else $error("synchronised fall missed"); // [RQ8]
endmodule

// ===== dv/gpxp_master.sv
`timescale 1ns/100ps
module gpxp_master (
  input wire logic clock, // system clock
  output gpxp_pkg::gpxp_req_type reg_req, // register request
  output logic rev_start, // revision command taken
  output logic rev_rd, // revision byte fetch
  input wire gpxp_pkg::gpxp_rsp_type reg_rsp // read answer
);
  initial
  begin
    reg_req = '0;
    rev_start = 1'b0;
    rev_rd = 1'b0;
  end
  // idle edge after a write so wr never toggles twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{1'b0, 1'b1, a, d};
    @(posedge clock);
    #1 reg_req.wr = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    reg_req = '{1'b1, 1'b0, a, 8'h00};
    @(posedge clock);
    #1 reg_req.rd = 1'b0;
    d = 8'hXX;
    for (i = 0; i < 4 && reg_rsp.valid !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
    end
    if (reg_rsp.valid === 1'b1)
      d = reg_rsp.data;
    // idle edge so a following request never re-raises rd in this time step
    @(posedge clock);
    #1;
  endtask
  task automatic rev(output logic [7:0] m, output logic [7:0] l);
    rev_start = 1'b1;
    @(posedge clock);
    #1 rev_start = 1'b0;
    rev_rd = 1'b1;
    @(posedge clock);
    #1 m = (reg_rsp.valid === 1'b1) ? reg_rsp.data : 8'hXX;
    @(posedge clock);
    #1 l = (reg_rsp.valid === 1'b1) ? reg_rsp.data : 8'hXX;
    rev_rd = 1'b0;
    @(posedge clock);
    #1;
  endtask
endmodule

// ===== dv/tb_gpio_expander_port_regs.sv
`timescale 1ns/100ps
module tb_gpio_expander_port_regs;
  logic clock;
  logic sys_rst;
  logic edge_pin;
  logic rev_start;
  logic rev_rd;
  logic int_n;
  logic [7:0] ext;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] d;
  logic [7:0] m;
  gpxp_pkg::gpxp_req_type reg_req;
  gpxp_pkg::gpxp_rsp_type reg_rsp;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  // released pins fall back to the outside world
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  gpxp_port #(.REV_MSB(8'h25), .REV_LSB(8'h07)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .rev_start(rev_start), .rev_rd(rev_rd), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .edge_irq_pin(edge_pin), .int_n(int_n));
  gpxp_master i_mst (.clock(clock), .reg_req(reg_req), .rev_start(rev_start),
    .rev_rd(rev_rd), .reg_rsp(reg_rsp));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic rd_all_zero;
    logic [7:0] addrs [4];
    addrs = '{gpxp_pkg::ADDR_MODE_LOW, gpxp_pkg::ADDR_LEVEL, gpxp_pkg::ADDR_MODE_HIGH, gpxp_pkg::ADDR_EDGE_CTL};
    foreach (addrs[i])
    begin
      i_mst.rd(addrs[i], d);
      chk(d, gpxp_pkg::REG_RESET);
    end
  endtask
  task automatic t_reset;
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'h00);
    #1 sys_rst = 1'b0;
    wait_n(1);
    rd_all_zero();
    i_mst.wr(8'h05, 8'hFF);
    i_mst.rd(8'h05, d);
    chk(d, 8'h00);
  endtask
  task automatic t_modes;
    i_mst.wr(8'h00, 8'hE4);
    i_mst.wr(8'h07, 8'h27);
    i_mst.wr(8'h01, 8'hA5);
    wait_n(3);
    chk(pin_oe, 8'h44);
    chk(pin_oe & pin_out, 8'h04);
    i_mst.rd(8'h00, d);
    chk(d, 8'hE4);
    i_mst.rd(8'h07, d);
    chk(d, 8'h27);
    ext = 8'h3C;
    i_mst.wr(8'h01, 8'h00);
    wait_n(3);
    chk(pin_oe, 8'hC5);
    i_mst.rd(8'h01, d);
    chk(d, 8'h38);
  endtask
  task automatic t_edge;
    i_mst.wr(8'h08, 8'h40);
    edge_pin = 1'b1;
    wait_n(5);
    chk({7'h00, int_n}, 8'h00);
    i_mst.rd(8'h08, d);
    chk(d, 8'hC0);
    chk({7'h00, int_n}, 8'h01);
    i_mst.rd(8'h08, d);
    chk(d, 8'h40);
    i_mst.wr(8'h08, 8'hFF);
    i_mst.rd(8'h08, d);
    chk(d, 8'h60);
    edge_pin = 1'b0;
    wait_n(5);
    i_mst.rd(8'h08, d);
    chk(d, 8'hE0);
    edge_pin = 1'b1;
    wait_n(5);
    i_mst.rd(8'h08, d);
    chk(d, 8'h60);
    i_mst.wr(8'h08, 8'h20);
    repeat (4)
    begin
      edge_pin = ~edge_pin;
      #100;
    end
    i_mst.rd(8'h08, d);
    chk(d, 8'h20);
    chk({7'h00, int_n}, 8'h01);
    i_mst.wr(8'h08, 8'h40);
    i_mst.rd(8'h08, d);
    chk(d, 8'h40);
  endtask
  // reset in mid-run with registers written and the interrupt pending
  task automatic t_rereset;
    i_mst.wr(gpxp_pkg::ADDR_MODE_LOW, 8'hAA);
    i_mst.wr(gpxp_pkg::ADDR_EDGE_CTL, 8'h60);
    edge_pin = 1'b0;
    wait_n(5);
    chk({7'h00, int_n}, 8'h00);
    sys_rst = 1'b1;
    wait_n(2);
    chk(pin_oe, gpxp_pkg::OE_RESET);
    chk(pin_out, 8'h00);
    chk({7'h00, int_n}, 8'h01);
    sys_rst = 1'b0;
    wait_n(1);
    rd_all_zero();
  endtask
  task automatic t_rev;
    i_mst.rev(m, d);
    chk(m, 8'h25);
    chk(d, 8'h07);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    ext = 8'hFF;
    edge_pin = 1'b0;
    repeat (20) @(posedge clock);
    t_reset();
    t_modes();
    t_edge();
    t_rereset();
    t_rev();
    wrap_up();
  end
endmodule
